//--- watchdog_params.svh
// Register map, field positions and timing constants of the watchdog
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH
`define WDG_ADDR_W           8
`define WDG_CONTROL_ADDR     8'hE1
`define WDG_STATUS_ADDR      8'hE2
`define WDG_MASK_ADDR        8'hE3
`define WDG_CAUSE_BIT        7
`define WDG_RUN_BIT          5
`define WDG_RESTART_BIT      4
`define WDG_SLEEP_BIT        3
`define WDG_PS_MSB           2
`define WDG_PS_LSB           0
`define WDG_CONTROL_WMASK    8'h3F
`define WDG_OSC_DIV          12
`define WDG_PRE_W            8
`define WDG_CNT_W            15
`define WDG_EV_OVF_BIT       0
`define WDG_EV_RESTART_BIT   1
`define WDG_EV_W             2
`endif

//--- watchdog_pkg.sv
// Types shared by the watchdog modules
package watchdog_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] prescale_sel_t;
    typedef enum logic [1:0]
    {
        ST_STOPPED = 2'b00,
        ST_RUNNING = 2'b01,
        ST_PAUSED  = 2'b11
    } run_state_t;
endpackage

//--- watchdog_tick_if.sv
// Interface carrying the count controls and overflow between modules
`timescale 1ns/1ps
interface watchdog_tick_if;
    logic                         count_en;
    logic                         restart;
    watchdog_pkg::prescale_sel_t  prescale;
    logic                         overflow;
    modport ctrl (output count_en, output restart, output prescale,
                  input overflow);
    modport core (input count_en, input restart, input prescale,
                  output overflow);
endinterface

//--- watchdog_counter.sv
// Divide-by-12 stage, 8-bit prescaler and 15-bit watchdog counter
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_counter
#(
    parameter int OSC_DIV = `WDG_OSC_DIV,
    parameter int PRE_W   = `WDG_PRE_W,
    parameter int CNT_W   = `WDG_CNT_W
)
(
    input  wire logic      clk_sys_in,
    input  wire logic      reset_n_in,
    watchdog_tick_if.core  tick
);
    import watchdog_pkg::*;

    logic [3:0]       osc_q;
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic             osc_tick;
    logic             pre_tick;
    logic [PRE_W-1:0] pre_top;

    // Ratio 2^(sel+1) means the prescaler wraps at that value minus one
    function automatic logic [PRE_W-1:0] ratio_top(input prescale_sel_t s);
        logic [PRE_W:0] r;
        // Shift amount is widened so that code 7 does not wrap to zero
        r = {{PRE_W{1'b0}}, 1'b1} << ({1'b0, s} + 4'h1);
        return r[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};
    endfunction

    assign osc_tick = tick.count_en && (osc_q == 4'(OSC_DIV - 1));
    assign pre_top  = ratio_top(tick.prescale);
    assign pre_tick = osc_tick && (pre_q >= pre_top);
    // Overflow is a single-cycle pulse on the counter's wrap
    assign tick.overflow = pre_tick && (&cnt_q);

    // System clock divided by 12, as the CPU machine cycle
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            osc_q <= 4'h0;
        else if (tick.restart)
            osc_q <= 4'h0;
        else if (osc_tick)
            osc_q <= 4'h0;
        else if (tick.count_en)
            osc_q <= osc_q + 4'h1;
    end

    // Prescaler; >= keeps it from running past a newly lowered top
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            pre_q <= '0;
        else if (tick.restart)
            pre_q <= '0;
        else if (pre_tick)
            pre_q <= '0;
        else if (osc_tick)
            pre_q <= pre_q + 1'b1;
    end

    // Main counter advanced by the prescaler output
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cnt_q <= '0;
        else if (tick.restart)
            cnt_q <= '0;
        else if (pre_tick)
            cnt_q <= cnt_q + 1'b1;
    end
endmodule // watchdog_counter

//--- watchdog_reset_timer.sv
// Watchdog control register, run control, reset request and interrupts
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_reset_timer
(
    input  wire logic                            clk_sys_in,
    input  wire logic                            reset_n_in,
    input  wire logic                            power_on_n_in,
    input  wire logic                            cpu_idle_in,
    input  wire logic [`WDG_ADDR_W-1:0]          addr_in,
    input  wire watchdog_pkg::byte_t             wdata_in,
    input  wire logic                            wr_in,
    input  wire logic                            rd_in,
    output watchdog_pkg::byte_t                  rdata_out,
    output logic                                 chip_reset_req_out,
    output logic                                 irq_out
);
    import watchdog_pkg::*;

    watchdog_tick_if tick ();

    logic                   idle_s1_q;
    logic                   idle_s2_q;
    logic                   por_s1_q;
    logic                   por_s2_q;
    logic                   cause_q;
    logic                   run_q;
    logic                   sleep_run_q;
    logic                   restart_q;
    prescale_sel_t          ps_q;
    run_state_t             state_q;
    run_state_t             state_d;
    logic [`WDG_EV_W-1:0]   status_q;
    logic [`WDG_EV_W-1:0]   mask_q;
    logic [`WDG_EV_W-1:0]   events;
    byte_t                  rdata_q;
    byte_t                  ctrl_view;
    logic                   wr_ctrl;
    logic                   wr_status;
    logic                   wr_mask;
    logic                   wdg_fire;

    // True when a bus strobe targets the given register address
    function automatic logic hit(input logic                   strobe,
                                 input logic [`WDG_ADDR_W-1:0] a,
                                 input logic [`WDG_ADDR_W-1:0] target);
        return strobe && (a == target);
    endfunction

    assign wr_ctrl   = hit(wr_in, addr_in, `WDG_CONTROL_ADDR);
    assign wr_status = hit(wr_in, addr_in, `WDG_STATUS_ADDR);
    assign wr_mask   = hit(wr_in, addr_in, `WDG_MASK_ADDR);
    assign wdg_fire  = tick.overflow;

    // Idle and power-on are asynchronous to this clock: two stages each
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            idle_s1_q <= 1'b0;
            idle_s2_q <= 1'b0;
            por_s1_q  <= 1'b0;
            por_s2_q  <= 1'b0;
        end
        else
        begin
            idle_s1_q <= cpu_idle_in;
            idle_s2_q <= idle_s1_q;
            por_s1_q  <= ~power_on_n_in;
            por_s2_q  <= por_s1_q;
        end
    end

    // Cause flag survives the watchdog's own reset; power-on or reset_n_in clears it.
    // The chip reset line is assumed not to be driven by our own request,
    // otherwise the flag would be wiped together with the rest.
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cause_q <= 1'b0;
        else if (wdg_fire)
            cause_q <= 1'b1;
        else if (por_s2_q)
            cause_q <= 1'b0;
    end

    // Control fields; an overflow returns them to zero like a chip reset
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            run_q       <= 1'b0;
            sleep_run_q <= 1'b0;
            ps_q        <= 3'h0;
        end
        else if (wdg_fire)
        begin
            run_q       <= 1'b0;
            sleep_run_q <= 1'b0;
            ps_q        <= 3'h0;
        end
        else if (wr_ctrl)
        begin
            run_q       <= wdata_in[`WDG_RUN_BIT];
            sleep_run_q <= wdata_in[`WDG_SLEEP_BIT];
            ps_q        <= wdata_in[`WDG_PS_MSB:`WDG_PS_LSB];
        end
    end

    // Restart bit is a one-cycle pulse that hardware drops by itself
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            restart_q <= 1'b0;
        else
            restart_q <= wr_ctrl && wdata_in[`WDG_RESTART_BIT];
    end

    // Run state: stopped, running, or paused while the CPU idles
    always_comb
    begin
        state_d = ST_STOPPED;
        if (run_q && !wdg_fire)
            state_d = (idle_s2_q && !sleep_run_q) ? ST_PAUSED
                                                  : ST_RUNNING;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_q <= ST_STOPPED;
        else
            state_q <= state_d;
    end

    // Counting only in the running state, so a stop can never overflow
    always_comb
    begin
        unique case (state_q)
            ST_RUNNING: tick.count_en = run_q;
            ST_PAUSED:  tick.count_en = 1'b0;
            ST_STOPPED: tick.count_en = 1'b0;
            default:    tick.count_en = 1'b0;
        endcase
    end

    // Counter zeroes on software restart and on its own overflow
    assign tick.restart  = restart_q || wdg_fire;
    assign tick.prescale = ps_q;

    watchdog_counter u_counter
    (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .tick       (tick)
    );

    // Single-cycle request to the chip reset logic
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            chip_reset_req_out <= 1'b0;
        else
            chip_reset_req_out <= wdg_fire;
    end

    // Sticky events: set wins over a write-one clear in the same cycle
    assign events[`WDG_EV_OVF_BIT]     = wdg_fire;
    assign events[`WDG_EV_RESTART_BIT] = restart_q;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            status_q <= '0;
        else if (wr_status)
            status_q <= (status_q & ~wdata_in[`WDG_EV_W-1:0]) | events;
        else
            status_q <= status_q | events;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            mask_q <= '0;
        else if (wr_mask)
            mask_q <= wdata_in[`WDG_EV_W-1:0];
    end

    assign irq_out = |(status_q & mask_q);

    // Control view: bit 6 unused reads zero, restart always reads zero
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[`WDG_CAUSE_BIT] = cause_q;
        ctrl_view[`WDG_RUN_BIT]   = run_q;
        ctrl_view[`WDG_SLEEP_BIT] = sleep_run_q;
        ctrl_view[`WDG_PS_MSB:`WDG_PS_LSB] = ps_q;
    end

    // Read data registered, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_q <= 8'h00;
        else if (!rd_in)
            rdata_q <= 8'h00;
        else if (addr_in == `WDG_CONTROL_ADDR)
            rdata_q <= ctrl_view;
        else if (addr_in == `WDG_STATUS_ADDR)
            rdata_q <= {{(8-`WDG_EV_W){1'b0}}, status_q};
        else if (addr_in == `WDG_MASK_ADDR)
            rdata_q <= {{(8-`WDG_EV_W){1'b0}}, mask_q};
        else
            rdata_q <= 8'h00;
    end

    assign rdata_out = rdata_q;
endmodule // watchdog_reset_timer

//--- watchdog_reset_timer_monitor.sv
// Assertion checker for the watchdog register port and reset request
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_reset_timer_monitor
(
    input wire logic                 clk_sys_in,
    input wire logic                 reset_n_in,
    input wire logic                 power_on_n_in,
    input wire logic                 cpu_idle_in,
    input wire logic [7:0]           addr_in,
    input wire watchdog_pkg::byte_t  wdata_in,
    input wire logic                 wr_in,
    input wire logic                 rd_in,
    input wire watchdog_pkg::byte_t  rdata_out,
    input wire logic                 chip_reset_req_out,
    input wire logic                 irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    // Read data only in the cycle after a read strobe
    property p_rdata_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_unused_bits;
        $past(rd_in) && $past(addr_in) == `WDG_CONTROL_ADDR
            |-> rdata_out[6] == 1'b0 && rdata_out[4] == 1'b0;
    endproperty
    a_unused_bits: assert property (p_unused_bits)
        else $error("control bit 6 or 4 read as one");
    property p_unmapped;
        rd_in && (addr_in < `WDG_CONTROL_ADDR || addr_in > `WDG_MASK_ADDR)
            |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // Write then read back: writable bits follow, restart reads zero
    property p_readback;
        wr_in && addr_in == `WDG_CONTROL_ADDR ##1
            rd_in && addr_in == `WDG_CONTROL_ADDR
            |=> rdata_out[5:0] == ($past(wdata_in[5:0], 2) & 6'h2F);
    endproperty
    a_readback: assert property (p_readback)
        else $error("control readback differs");
    property p_req_pulse;
        chip_reset_req_out |=> !chip_reset_req_out;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("reset request longer than one cycle");
    // Overflow is far away, so no request right after reset
    property p_no_early_req;
        $rose(reset_n_in) |-> !chip_reset_req_out [*8];
    endproperty
    a_no_early_req: assert property (p_no_early_req)
        else $error("reset request right after reset");
    property p_cause_clear;
        !power_on_n_in [*3] ##0 (rd_in && addr_in == `WDG_CONTROL_ADDR)
            |=> !rdata_out[7];
    endproperty
    a_cause_clear: assert property (p_cause_clear)
        else $error("cause flag set after power-on");
    property p_irq_masked;
        wr_in && addr_in == `WDG_MASK_ADDR && wdata_in == 8'h00 |=> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with mask cleared");
endmodule // watchdog_reset_timer_monitor

bind watchdog_reset_timer watchdog_reset_timer_monitor u_mon
(
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .power_on_n_in(power_on_n_in), .cpu_idle_in(cpu_idle_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .chip_reset_req_out(chip_reset_req_out),
    .irq_out(irq_out)
);

//--- watchdog_reset_timer_test.sv
// Self-checking bench for the watchdog register block
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_reset_timer_test;
    import watchdog_pkg::*;
    logic        clk_sys_in = 0, reset_n_in = 0, power_on_n_in = 1;
    logic        cpu_idle_in = 0, wr_in = 0, rd_in = 0, rd_seen = 0;
    logic [7:0]  addr_in = 8'h00;
    byte_t       wdata_in = 8'h00, rdata_out, v;
    logic        chip_reset_req_out, irq_out;
    byte_t       exp_q[$];
    int          miscompares = 0, n_compared = 0, cycles = 0, req_seen = 0;
    logic [31:0] seed = 32'h9AD33E56;

    always #5 clk_sys_in = ~clk_sys_in;

    watchdog_reset_timer dut
    (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .power_on_n_in(power_on_n_in), .cpu_idle_in(cpu_idle_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out),
        .chip_reset_req_out(chip_reset_req_out), .irq_out(irq_out)
    );

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(string name, byte_t seen, byte_t exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One bus cycle; the next call overwrites, so strobes stay one cycle
    task automatic bus(logic w, logic r, logic [7:0] a, byte_t d);
        @(posedge clk_sys_in);
        wr_in    <= w;
        rd_in    <= r;
        addr_in  <= a;
        wdata_in <= d;
    endtask

    task automatic rd(logic [7:0] a, byte_t exp);
        exp_q.push_back(exp);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle();
        bus(1'b0, 1'b0, addr_in, 8'h00);
    endtask

    // Cycle count, request count and hang limit
    always @(posedge clk_sys_in)
    begin
        rd_seen <= rd_in;
        cycles++;
        if (chip_reset_req_out === 1'b1)
            req_seen++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // Read data is settled at the falling edge of its one valid cycle
    always @(negedge clk_sys_in)
        if (rd_seen === 1'b1)
            check("rdata_out", rdata_out, exp_q.pop_front());

    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        v = xorshift();
        rd(`WDG_CONTROL_ADDR, 8'h00);
        rd(`WDG_STATUS_ADDR, 8'h00);
        rd(`WDG_MASK_ADDR, 8'h00);
        rd({4'h1, v[3:0]}, 8'h00);
        // Every prescale code, with random run, idle and read-only bits
        for (int c = 0; c < 8; c++)
        begin
            v = (xorshift() & 8'hE8) | byte_t'(c);
            cpu_idle_in <= v[7];
            bus(1'b1, 1'b0, `WDG_CONTROL_ADDR, v);
            rd(`WDG_CONTROL_ADDR, v & 8'h2F);
        end
        // Restart self-clears and raises its event
        bus(1'b1, 1'b0, `WDG_CONTROL_ADDR, 8'h3B);
        rd(`WDG_CONTROL_ADDR, 8'h2B);
        rd(`WDG_STATUS_ADDR, 8'h02);
        bus(1'b1, 1'b0, `WDG_MASK_ADDR, 8'h02);
        idle();
        @(negedge clk_sys_in);
        check("irq_out", {7'h00, irq_out}, 8'h01);
        bus(1'b1, 1'b0, `WDG_MASK_ADDR, 8'h00);
        idle();
        @(negedge clk_sys_in);
        check("irq_out", {7'h00, irq_out}, 8'h00);
        bus(1'b1, 1'b0, `WDG_MASK_ADDR, 8'h02);
        bus(1'b1, 1'b0, `WDG_STATUS_ADDR, 8'h02);
        idle();
        @(negedge clk_sys_in);
        check("irq_out", {7'h00, irq_out}, 8'h00);
        rd(`WDG_STATUS_ADDR, 8'h00);
        // Stop, then a power-on start leaves the cause flag clear
        bus(1'b1, 1'b0, `WDG_CONTROL_ADDR, 8'h00);
        rd(`WDG_CONTROL_ADDR, 8'h00);
        power_on_n_in <= 1'b0;
        repeat (3) idle();
        rd(`WDG_CONTROL_ADDR, 8'h00);
        idle();
        power_on_n_in <= 1'b1;
        // Running far short of overflow must never request a reset
        bus(1'b1, 1'b0, `WDG_CONTROL_ADDR, 8'h28);
        for (int k = 0; k < 3; k++)
        begin
            repeat (1000) idle();
            bus(1'b1, 1'b0, `WDG_CONTROL_ADDR, 8'h38);
        end
        rd(`WDG_STATUS_ADDR, 8'h02);
        check("reset requests", byte_t'(req_seen), 8'h00);
        repeat (2) idle();
        end_of_test();
    end
endmodule // watchdog_reset_timer_test
